// ===== rtl/io_logic_pkg.sv
/*
 * constants, source and route numbering, and carrier types of the io logic block.
 * assumes a 32-bit classic wishbone slave and one 100 MHz clock.
 */
package io_logic_pkg;

	localparam int CLK_MHZ = 100;

	// byte offsets
	localparam logic [11:0] OFS_FLAGS      = 12'h000;
	localparam logic [11:0] OFS_CTRL       = 12'h004;
	localparam logic [11:0] OFS_STATUS     = 12'h008;
	localparam logic [11:0] OFS_CODES      = 12'h00c;
	localparam logic [11:0] OFS_ROUTE_BASE = 12'h100;

	// ctrl field positions
	localparam int CTRL_DECODE_LSB = 0;
	localparam int CTRL_CONNECT    = 2;
	localparam int CTRL_GINV_LSB   = 3;
	localparam int CTRL_IINV_LSB   = 9;

	// reset values
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0004;
	localparam logic [3:0]  FLAGS_RESET = 4'h0;

	// decode settings
	localparam logic [1:0] DEC_ONE_PER_LINE = 2'h0;
	localparam logic [1:0] DEC_BINARY_PLUS  = 2'h1;
	localparam logic [1:0] DEC_BINARY       = 2'h2;

	localparam logic [6:0] DEC_BINARY_MAX = 7'h40;

	// source pool numbering
	localparam int SRC_LOW   = 0;
	localparam int SRC_MB    = 1;
	localparam int SRC_EXP   = 7;
	localparam int SRC_FLAG  = 19;
	localparam int SRC_AND   = 23;
	localparam int SRC_OR    = 25;
	localparam int SRC_SEL   = 27;
	localparam int SRC_AUTO  = 29;
	localparam int SRC_HV    = 30;
	localparam int SRC_COUNT = 32;

	// route numbering
	localparam int RT_SET     = 0;
	localparam int RT_CLR     = 4;
	localparam int RT_TOG     = 8;
	localparam int RT_AND     = 12;
	localparam int RT_OR      = 18;
	localparam int RT_SELC    = 24;
	localparam int RT_SELL    = 26;
	localparam int RT_SELH    = 28;
	localparam int RT_RELAY   = 30;
	localparam int RT_CRUC_EN = 32;
	localparam int RT_CRUC    = 33;
	localparam int RT_REC_EN  = 45;
	localparam int RT_REC     = 46;
	localparam int RT_COUNT   = 52;

	localparam logic [4:0] ROUTE_SRC_RESET = 5'h00;

	typedef struct packed {
		logic       inv;
		logic [4:0] src;
	} route_t;

	typedef struct packed {
		logic [5:0] input_inv;
		logic [5:0] gate_inv;
		logic       connected;
		logic [1:0] decode;
	} ctrl_t;

endpackage

// ===== rtl/mapped_signal.sv
/*
 * one mapped output: picks a source from the pool and optionally inverts it.
 * assumes the pool holds registered signals only, so no loop can form.
 */
`timescale 1ns/1ns
module mapped_signal #(
	parameter int SRC_W = 32
) (
	input  wire logic [SRC_W-1:0]       pool_i,
	input  wire io_logic_pkg::route_t   cfg_i,
	output wire logic                   value_o
);

	wire logic picked;

	assign picked  = pool_i[cfg_i.src];
	assign value_o = picked ^ cfg_i.inv;

endmodule

// ===== rtl/io_logic.sv
/*
 * configurable io logic: user flags, six gates, input conditioning, relays,
 * crucible and recipe select decoding, all behind a classic wishbone slave.
 * assumes field inputs are asynchronous and the bus is on clk_i.
 */
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ns
// What this block does
// - four flags writable to 1 or 0
// - flag one settable by remote, use shown
// - set request forces flag to 1 unless clear is requested in the same cycle
// - clear request forces flag to 0
// - toggle request rising edge inverts flag
// - six gates usable as mapped sources
// - and gate of three, optional inversion
// - or gate of three, optional inversion
// - selector low/high by choice, optional invert
// - main-board input 1 is water interlock
// - main-board input 2 is vacuum interlock
// - inputs read 1 with voltage, invertible
// - relay closed while its source is 1
// - setting 0: one line per crucible
// - setting 2: binary code up to 64
// - disconnected recipes select independently of crucible
// - select source 0 means remote chooses
// - decoder 0 leaves choice to remote
module io_logic #(
	parameter int MB_INPUTS  = 6,
	parameter int EXP_INPUTS = 12
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [11:0]           wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic                       wb_ack_o,
	output logic      [31:0]           wb_dat_o,
	input  wire logic [MB_INPUTS-1:0]  main_board_input_i,
	input  wire logic [EXP_INPUTS-1:0] expansion_input_i,
	input  wire logic                  auto_mode_i,
	input  wire logic                  hv_on_i,
	input  wire logic                  remote_write_i,
	input  wire logic                  remote_value_i,
	output logic [1:0]                 main_board_relay_o,
	output logic                       water_interlock_o,
	output logic                       vacuum_interlock_o,
	output logic [3:0]                 flag_o,
	output logic                       flag1_in_use_o,
	output logic [6:0]                 crucible_code_o,
	output logic                       crucible_by_lines_o,
	output logic [6:0]                 recipe_code_o,
	output logic                       recipe_by_lines_o
);

	localparam int SYNC_W = MB_INPUTS + EXP_INPUTS + 2;

	// input synchronisers
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	wire  [SYNC_W-1:0] raw_in;

	assign raw_in = {hv_on_i, auto_mode_i, expansion_input_i, main_board_input_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	// configuration state
	io_logic_pkg::ctrl_t  ctrl;
	io_logic_pkg::route_t route_cfg [io_logic_pkg::RT_COUNT];
	logic [3:0]           flags;
	logic [1:0]           and_res;
	logic [1:0]           or_res;
	logic [1:0]           sel_res;
	logic [3:0]           tog_prev;

	// main-board inputs with optional inversion
	wire logic [MB_INPUTS-1:0] mb_cond;
	assign mb_cond = sync_b[MB_INPUTS-1:0] ^ ctrl.input_inv[MB_INPUTS-1:0];

	// source pool, all registered
	wire logic [io_logic_pkg::SRC_COUNT-1:0] pool;
	assign pool = {1'b0, sync_b[SYNC_W-1], sync_b[SYNC_W-2], sel_res, or_res, and_res, flags,
	               sync_b[MB_INPUTS +: EXP_INPUTS], mb_cond, 1'b0};

	// every mapped output
	wire logic [io_logic_pkg::RT_COUNT-1:0] rt;

	genvar gi;
	generate
		for (gi = 0; gi < io_logic_pkg::RT_COUNT; gi++) begin : g_route
			mapped_signal #(
				.SRC_W (io_logic_pkg::SRC_COUNT)
			) u_map (
				.pool_i  (pool),
				.cfg_i   (route_cfg[gi]),
				.value_o (rt[gi])
			);
		end
	endgenerate

	// gates
	wire logic [1:0] next_and;
	wire logic [1:0] next_or;
	wire logic [1:0] next_sel;

	generate
		for (gi = 0; gi < 2; gi++) begin : g_gate
			assign next_and[gi] = (&rt[io_logic_pkg::RT_AND + 3*gi +: 3]) ^ ctrl.gate_inv[gi];
			assign next_or[gi]  = (|rt[io_logic_pkg::RT_OR + 3*gi +: 3]) ^ ctrl.gate_inv[2+gi];
			assign next_sel[gi] = (rt[io_logic_pkg::RT_SELC+gi] ? rt[io_logic_pkg::RT_SELH+gi]
			                      : rt[io_logic_pkg::RT_SELL+gi]) ^ ctrl.gate_inv[4+gi];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			and_res <= '0;
			or_res  <= '0;
			sel_res <= '0;
		end else begin
			and_res <= next_and;
			or_res  <= next_or;
			sel_res <= next_sel;
		end
	end

	// bus decode
	wire logic        bus_req;
	wire logic        bus_wr;
	wire logic        sel_flags;
	wire logic        sel_ctrl;
	wire logic        sel_status;
	wire logic        sel_codes;
	wire logic        sel_route;
	wire logic [5:0]  route_idx;
	wire logic [11:0] route_ofs;

	assign bus_req    = wb_cyc_i & wb_stb_i;
	assign bus_wr     = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign route_ofs  = wb_adr_i - io_logic_pkg::OFS_ROUTE_BASE;
	assign route_idx  = route_ofs[7:2];
	assign sel_flags  = wb_adr_i == io_logic_pkg::OFS_FLAGS;
	assign sel_ctrl   = wb_adr_i == io_logic_pkg::OFS_CTRL;
	assign sel_status = wb_adr_i == io_logic_pkg::OFS_STATUS;
	assign sel_codes  = wb_adr_i == io_logic_pkg::OFS_CODES;
	assign sel_route  = wb_adr_i >= io_logic_pkg::OFS_ROUTE_BASE && wb_adr_i[1:0] == 2'h0
	                    && route_ofs[11:2] < 10'(io_logic_pkg::RT_COUNT);

	wire logic [31:0] rd_route;
	wire logic [31:0] rd_value;

	assign rd_route = sel_route ? {26'h0, route_cfg[route_idx]} : 32'h0;
	assign rd_value = sel_flags  ? {28'h0, flags} :
	                  sel_ctrl   ? {17'h0, ctrl} :
	                  sel_status ? {18'h0, sel_res, or_res, and_res, 2'h0, mb_cond} :
	                  sel_codes  ? {16'h0, recipe_by_lines_o, recipe_code_o, crucible_by_lines_o,
	                                crucible_code_o} :
	                  rd_route;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			wb_dat_o <= rd_value;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= io_logic_pkg::ctrl_t'(io_logic_pkg::CTRL_RESET[14:0]);
		end else if (bus_wr && sel_ctrl) begin
			ctrl <= io_logic_pkg::ctrl_t'(wb_dat_i[14:0]);
		end
	end

	generate
		for (gi = 0; gi < io_logic_pkg::RT_COUNT; gi++) begin : g_route_reg
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					route_cfg[gi] <= '{inv: 1'b0, src: io_logic_pkg::ROUTE_SRC_RESET};
				end else if (bus_wr && sel_route && route_idx == 6'(gi)) begin
					route_cfg[gi] <= io_logic_pkg::route_t'(wb_dat_i[5:0]);
				end
			end
		end
	endgenerate

	// user flags
	wire logic [3:0] next_flags;
	wire logic [3:0] tog_now;
	wire logic [3:0] sw_wr;
	wire logic [3:0] sw_val;

	assign tog_now = rt[io_logic_pkg::RT_TOG +: 4];
	assign sw_wr   = {3'h0, remote_write_i} | {4{bus_wr && sel_flags}};
	assign sw_val  = (bus_wr && sel_flags) ? wb_dat_i[3:0] : {flags[3:1], remote_value_i};

	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			assign next_flags[gi] = rt[io_logic_pkg::RT_CLR+gi] ? 1'b0 :
			                        rt[io_logic_pkg::RT_SET+gi] ? 1'b1 :
			                        (tog_now[gi] & ~tog_prev[gi]) ? ~flags[gi] :
			                        sw_wr[gi] ? sw_val[gi] : flags[gi];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags    <= io_logic_pkg::FLAGS_RESET;
			tog_prev <= '0;
		end else begin
			flags    <= next_flags;
			tog_prev <= tog_now;
		end
	end

	// flag one in use by any route
	wire logic [io_logic_pkg::RT_COUNT-1:0] uses_flag1;
	generate
		for (gi = 0; gi < io_logic_pkg::RT_COUNT; gi++) begin : g_use
			assign uses_flag1[gi] = route_cfg[gi].src == 5'(io_logic_pkg::SRC_FLAG);
		end
	endgenerate

	// select decoding
	function automatic logic [6:0] decode_lines(input logic [1:0] mode, input logic [11:0] lines);
		logic [6:0] code;
		code = 7'h00;
		case (mode)
			io_logic_pkg::DEC_ONE_PER_LINE: begin
				for (int i = 11; i >= 0; i--) begin
					if (lines[i]) begin
						code = 7'(i + 1);
					end
				end
			end
			io_logic_pkg::DEC_BINARY_PLUS: begin
				if (lines[11:6] == 6'h00) begin
					code = {1'b0, lines[5:0]} + 7'h01;
				end
			end
			io_logic_pkg::DEC_BINARY: begin
				if (lines[11:7] == 5'h00 && lines[6:0] <= io_logic_pkg::DEC_BINARY_MAX) begin
					code = lines[6:0];
				end
			end
			default: begin
				code = 7'h00;
			end
		endcase
		return code;
	endfunction

	wire logic [6:0] cruc_dec;
	wire logic [6:0] rec_dec;
	wire logic [6:0] next_cruc;
	wire logic [6:0] next_rec;

	assign cruc_dec  = decode_lines(ctrl.decode, rt[io_logic_pkg::RT_CRUC +: 12]);
	assign rec_dec   = decode_lines(ctrl.decode, {6'h00, rt[io_logic_pkg::RT_REC +: 6]});
	assign next_cruc = rt[io_logic_pkg::RT_CRUC_EN] ? cruc_dec : 7'h00;
	assign next_rec  = ctrl.connected ? next_cruc :
	                   (rt[io_logic_pkg::RT_REC_EN] ? rec_dec : 7'h00);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_board_relay_o  <= 2'h0;
			water_interlock_o   <= 1'b0;
			vacuum_interlock_o  <= 1'b0;
			flag_o              <= io_logic_pkg::FLAGS_RESET;
			flag1_in_use_o      <= 1'b0;
			crucible_code_o     <= 7'h00;
			crucible_by_lines_o <= 1'b0;
			recipe_code_o       <= 7'h00;
			recipe_by_lines_o   <= 1'b0;
		end else begin
			main_board_relay_o  <= rt[io_logic_pkg::RT_RELAY +: 2];
			water_interlock_o   <= mb_cond[0];
			vacuum_interlock_o  <= mb_cond[1];
			flag_o              <= flags;
			flag1_in_use_o      <= |uses_flag1;
			crucible_code_o     <= next_cruc;
			crucible_by_lines_o <= next_cruc != 7'h00;
			recipe_code_o       <= next_rec;
			recipe_by_lines_o   <= next_rec != 7'h00;
		end
	end

	// checks
	a_relay_follows_src: assert property (@(posedge clk_i) disable iff (rst_i)
		main_board_relay_o == $past(rt[io_logic_pkg::RT_RELAY +: 2]))
		else $error("relay does not follow its source");
	a_clear_beats_set: assert property (@(posedge clk_i) disable iff (rst_i)
		rt[io_logic_pkg::RT_CLR] |=> !flags[0])
		else $error("clear request did not clear flag");
	a_set_forces_one: assert property (@(posedge clk_i) disable iff (rst_i)
		rt[io_logic_pkg::RT_SET+1] && !rt[io_logic_pkg::RT_CLR+1] |=> flags[1])
		else $error("set request did not set flag");
	a_toggle_inverts: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(tog_now[2]) && !rt[io_logic_pkg::RT_CLR+2] && !rt[io_logic_pkg::RT_SET+2]
		|=> flags[2] != $past(flags[2]))
		else $error("toggle edge did not invert flag");
	a_and_gate_value: assert property (@(posedge clk_i) disable iff (rst_i)
		and_res[0] == ((&$past(rt[io_logic_pkg::RT_AND +: 3])) ^ $past(ctrl.gate_inv[0])))
		else $error("and gate result wrong");
	a_or_gate_value: assert property (@(posedge clk_i) disable iff (rst_i)
		or_res[0] == ((|$past(rt[io_logic_pkg::RT_OR +: 3])) ^ $past(ctrl.gate_inv[2])))
		else $error("or gate result wrong");
	a_selector_high: assert property (@(posedge clk_i) disable iff (rst_i)
		rt[io_logic_pkg::RT_SELC] && !ctrl.gate_inv[4] |=> sel_res[0] == $past(rt[io_logic_pkg::RT_SELH]))
		else $error("selector did not pass high source");
	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_water_interlock: assert property (@(posedge clk_i) disable iff (rst_i)
		water_interlock_o == $past(sync_b[0] ^ ctrl.input_inv[0]))
		else $error("water interlock does not follow input 1");
	a_remote_select: assert property (@(posedge clk_i) disable iff (rst_i)
		!rt[io_logic_pkg::RT_CRUC_EN] |=> crucible_code_o == 7'h00 && !crucible_by_lines_o)
		else $error("crucible chosen by lines while source is 0");

endmodule

// ===== dv/field_model.sv
/*
 * field side of the io logic block: switches, interlock contacts and relay loads.
 * assumes the bench sets switch levels off the clock edge and reads contact states.
 */
`timescale 1ns/1ns
module field_model (
	input  wire logic [5:0]  mb_level_i,
	input  wire logic [11:0] exp_level_i,
	input  wire logic        auto_level_i,
	input  wire logic        hv_level_i,
	input  wire logic [1:0]  relay_i,
	output wire logic [5:0]  mb_pin_o,
	output wire logic [11:0] exp_pin_o,
	output wire logic        auto_pin_o,
	output wire logic        hv_pin_o,
	output wire logic [1:0]  contact_o
);
	// bit0 water, bit1 vacuum; 1 means voltage on the terminal
	assign mb_pin_o   = mb_level_i;
	assign exp_pin_o  = exp_level_i;
	assign auto_pin_o = auto_level_i;
	assign hv_pin_o   = hv_level_i;
	// contact closed while the relay is driven
	assign contact_o  = relay_i;
endmodule

// ===== dv/test_io_logic.sv
/*
 * self-checking bench of the io logic block over classic wishbone.
 * assumes one 100 MHz clock, a synchronous reset and the field model.
 */
`timescale 1ns/1ns
module test_io_logic;
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [11:0] adr     = 12'h000;
	logic [3:0]  sel     = 4'h0;
	logic [31:0] dat     = 32'h0;
	logic [5:0]  mb      = 6'h00;
	logic [11:0] ex      = 12'h000;
	logic        auto_l  = 1'b0;
	logic        hv_l    = 1'b0;
	logic        rem_wr  = 1'b0;
	logic        rem_val = 1'b0;
	logic [31:0] rd;
	wire         ack;
	wire  [31:0] rdat;
	wire  [5:0]  mb_pin;
	wire  [11:0] ex_pin;
	wire         auto_pin;
	wire         hv_pin;
	wire  [1:0]  relay;
	wire  [1:0]  contact;
	wire         water;
	wire         vacuum;
	wire  [3:0]  flag;
	wire         in_use;
	wire  [6:0]  cruc;
	wire  [6:0]  rec;
	wire         cruc_lines;
	wire         rec_lines;
	int          errors  = 0;
	int          checks  = 0;
	int          cycles  = 0;

	always #5 clk_i = ~clk_i;

	io_logic u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.main_board_input_i(mb_pin), .expansion_input_i(ex_pin), .auto_mode_i(auto_pin),
		.hv_on_i(hv_pin), .remote_write_i(rem_wr), .remote_value_i(rem_val),
		.main_board_relay_o(relay), .water_interlock_o(water), .vacuum_interlock_o(vacuum),
		.flag_o(flag), .flag1_in_use_o(in_use), .crucible_code_o(cruc),
		.crucible_by_lines_o(cruc_lines), .recipe_code_o(rec), .recipe_by_lines_o(rec_lines));

	field_model u_field (.mb_level_i(mb), .exp_level_i(ex), .auto_level_i(auto_l), .hv_level_i(hv_l),
		.relay_i(relay), .mb_pin_o(mb_pin), .exp_pin_o(ex_pin), .auto_pin_o(auto_pin),
		.hv_pin_o(hv_pin), .contact_o(contact));

	task automatic complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			complete_run();
		end
	end

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && cycles < 5990);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task automatic check_pin(input string name, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s exp %h seen %h", name, e, s);
		end
	endtask

	task automatic check_reg(input string name, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check_pin(name, e, rd & m);
	endtask

	task automatic route(input int idx, input logic inv, input int src);
		bus(1'b1, io_logic_pkg::OFS_ROUTE_BASE + 12'(4 * idx), {26'h0, inv, 5'(src)});
	endtask

	task automatic settle;
		repeat (6) @(posedge clk_i);
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		check_reg("ctrl", io_logic_pkg::OFS_CTRL, 32'hffff_ffff, io_logic_pkg::CTRL_RESET);
		check_reg("route", io_logic_pkg::OFS_ROUTE_BASE, 32'hffff_ffff, 32'h0);
		check_pin("in_use_reset", 32'h0, 32'(in_use));
		bus(1'b1, 12'h300, 32'hffff_ffff);
		check_reg("unmapped", 12'h300, 32'hffff_ffff, 32'h0);
		bus(1'b1, io_logic_pkg::OFS_FLAGS, 32'ha);
		check_reg("flags", io_logic_pkg::OFS_FLAGS, 32'hffff_ffff, 32'ha);
		settle();
		check_pin("flag_o", 32'ha, 32'(flag));
		bus(1'b1, io_logic_pkg::OFS_FLAGS, 32'h0);
		route(31, 1'b1, io_logic_pkg::SRC_LOW);
		route(1, 1'b0, io_logic_pkg::SRC_MB + 4);
		route(5, 1'b0, io_logic_pkg::SRC_MB + 5);
		route(10, 1'b0, io_logic_pkg::SRC_EXP);
		mb <= 6'h10;
		settle();
		check_pin("contact2", 32'h1, 32'(contact[1]));
		check_pin("set", 32'h1, 32'(flag[1]));
		mb <= 6'h30;
		settle();
		check_pin("clear", 32'h0, 32'(flag[1]));
		for (int i = 0; i < 2; i++) begin
			ex <= 12'h001;
			settle();
			ex <= 12'h000;
			settle();
			check_pin("toggle", 32'(i == 0), 32'(flag[2]));
		end
		mb <= 6'h25;
		settle();
		check_reg("inputs", io_logic_pkg::OFS_STATUS, 32'h3f, 32'h25);
		check_pin("water", 32'h1, 32'(water));
		check_pin("vacuum", 32'h0, 32'(vacuum));
		bus(1'b1, io_logic_pkg::OFS_CTRL, 32'h7e04);
		settle();
		check_reg("inv_inputs", io_logic_pkg::OFS_STATUS, 32'h3f, 32'h1a);
		check_pin("water_inv", 32'h0, 32'(water));
		check_pin("vacuum_inv", 32'h1, 32'(vacuum));
		route(12, 1'b0, io_logic_pkg::SRC_MB + 3);
		route(13, 1'b0, io_logic_pkg::SRC_MB + 4);
		route(14, 1'b1, io_logic_pkg::SRC_LOW);
		route(18, 1'b0, io_logic_pkg::SRC_HV);
		route(19, 1'b0, io_logic_pkg::SRC_MB + 2);
		route(24, 1'b0, io_logic_pkg::SRC_AUTO);
		route(26, 1'b0, io_logic_pkg::SRC_FLAG);
		route(28, 1'b0, io_logic_pkg::SRC_MB + 5);
		route(30, 1'b0, io_logic_pkg::SRC_SEL);
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, io_logic_pkg::OFS_CTRL, p ? 32'hac : 32'h4);
			for (int v = 0; v < 16; v++) begin
				mb <= {1'b0, v[2], v[1], v[0], 2'b00};
				hv_l <= v[3];
				settle();
				check_reg("gates", io_logic_pkg::OFS_STATUS, 32'h500,
					{21'h0, 1'(p ^ (v[3] | v[0])), 1'b0, 1'(p ^ (v[1] & v[2])), 8'h0});
			end
			for (int c = 0; c < 4; c++) begin
				bus(1'b1, io_logic_pkg::OFS_FLAGS, {31'h0, ~c[1]});
				auto_l <= c[0];
				mb <= {c[1], 5'h00};
				settle();
				check_pin("selector", 32'(p ^ (c[0] ? c[1] : !c[1])), 32'(relay[0]));
				check_pin("contact1", 32'(p ^ (c[0] ? c[1] : !c[1])), 32'(contact[0]));
			end
		end
		check_pin("in_use", 32'h1, 32'(in_use));
		bus(1'b1, io_logic_pkg::OFS_FLAGS, 32'h0);
		rem_wr <= 1'b1;
		rem_val <= 1'b1;
		@(posedge clk_i);
		rem_wr <= 1'b0;
		settle();
		check_pin("remote", 32'h1, 32'(flag[0]));
		bus(1'b1, io_logic_pkg::OFS_CTRL, 32'h4);
		route(32, 1'b0, io_logic_pkg::SRC_AUTO);
		for (int i = 0; i < 12; i++) begin
			route(33 + i, 1'b0, io_logic_pkg::SRC_EXP + i);
		end
		auto_l <= 1'b1;
		ex <= 12'h004;
		settle();
		check_pin("one_line", 32'h83, {24'h0, cruc_lines, cruc});
		check_pin("linked", 32'h3, 32'(rec));
		ex <= 12'h0a0;
		settle();
		check_pin("lowest_line", 32'h6, 32'(cruc));
		bus(1'b1, io_logic_pkg::OFS_CTRL, 32'h6);
		ex <= 12'h021;
		settle();
		check_pin("binary", 32'h21, 32'(cruc));
		bus(1'b1, io_logic_pkg::OFS_CTRL, 32'h5);
		settle();
		check_pin("binary_plus", 32'h22, 32'(cruc));
		auto_l <= 1'b0;
		settle();
		check_pin("remote_sel", 32'h0, {24'h0, cruc_lines, cruc});
		auto_l <= 1'b1;
		bus(1'b1, io_logic_pkg::OFS_CTRL, 32'h2);
		settle();
		check_reg("codes", io_logic_pkg::OFS_CODES, 32'hffff, 32'h00a1);
		route(45, 1'b0, io_logic_pkg::SRC_AUTO);
		route(46, 1'b0, io_logic_pkg::SRC_EXP);
		settle();
		check_pin("recipe", 32'h81, {24'h0, rec_lines, rec});
		check_pin("crucible_kept", 32'h21, 32'(cruc));
		complete_run();
	end
endmodule
